// ---- pkg/sec_map.svh ----
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

// ---------------------------------------------------------------
// Command byte
// ---------------------------------------------------------------
`define SEC_DEV_ADDR     4'hB
`define SEC_OP_RD_USER   4'h2
`define SEC_OP_SYS_WR    4'h4
`define SEC_OP_SYS_RD    4'h6

// ---------------------------------------------------------------
// First address byte of system write and system read
// ---------------------------------------------------------------
`define SEC_SW_CFG       8'h00
`define SEC_SW_FUSE      8'h01
`define SEC_SW_CKSUM     8'h02
`define SEC_SW_ZONE      8'h03
`define SEC_SW_CFG_AT    8'h08
`define SEC_SW_ZONE_AT   8'h0B
`define SEC_SR_CFG       8'h00
`define SEC_SR_FUSE      8'h01
`define SEC_SR_CKSUM     8'h02

// ---------------------------------------------------------------
// Fuse identifiers and fuse byte positions
// ---------------------------------------------------------------
`define SEC_FID_LOT      8'h07
`define SEC_FID_FACT     8'h06
`define SEC_FID_CARD     8'h04
`define SEC_FID_FINAL    8'h00
`define SEC_FB_FACT      0
`define SEC_FB_CARD      1
`define SEC_FB_FINAL     2
`define SEC_FB_LOT       3

// ---------------------------------------------------------------
// Counts and configuration memory layout
// ---------------------------------------------------------------
`define SEC_PAGE_MAX     5'h10
`define SEC_AT_MAX       5'h08
`define SEC_CNT_ZERO     9'h100
`define SEC_CK_BYTES     2'h2
`define SEC_CFG_DEVCFG   8'h18
`define SEC_CFG_RO_END   8'h0A
`define SEC_CFG_SECURE   8'hB0
`define SEC_CFG_RESET    8'hFF

`endif

// ---- pkg/sec_pkg.sv ----
package sec_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD  = 3'h1,
		ST_A1   = 3'h3,
		ST_A2   = 3'h2,
		ST_CNT  = 3'h6,
		ST_WR   = 3'h7,
		ST_RD   = 3'h5,
		ST_SKIP = 3'h4
	} sec_state_t;

	typedef enum logic [1:0] {
		SRC_USER = 2'h0,
		SRC_CFG  = 2'h1,
		SRC_FUSE = 2'h2,
		SRC_CK   = 2'h3
	} sec_src_t;

	typedef struct packed {
		logic [7:0]  zone;
		logic [15:0] offset;
	} sec_uaddr_t;

endpackage : sec_pkg

// ---- rtl/sec_sys_cmd.sv ----
`timescale 1ns/100ps
`include "sec_map.svh"

// How it works
// - User read from address, count zero is 256
// - Read address wraps inside selected zone
// - No read right: count byte not acknowledged
// - System write dispatches on first address byte
// - Any forbidden byte suppresses whole config write
// - Fuse bits only ever go one to zero
// - Fuse programming needs secure code first
// - Factory, card, final fuses in order; lot fuse any time
// - Held user write commits on valid checksum
// - Wrong checksum revokes authentication
// - Zone select 0x0B turns anti-tearing on
// - Config write 0x08 uses anti-tearing, eight max
// - System read dispatches on first address byte
// - Config read from address, count zero is 256
// - Forbidden config read start: NACK, no data
// - Forbidden bytes mid-read send fuse byte
// - Fuse byte layout, zero means programmed
// - Bytes travel most significant bit first
// - Answer address nibble 0xB or configured nibble
module sec_sys_cmd #(
	parameter int         ZONE_BYTES = 256,
	parameter logic [3:0] FUSE_INIT  = 4'hF
) (
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              link_clk_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	input  wire logic              secure_ok_i,
	input  wire logic              zone_read_ok_i,
	input  wire logic              user_wr_pending_i,
	input  wire logic [15:0]       checksum_i,
	input  wire logic [7:0]        user_data_i,
	output sec_pkg::sec_uaddr_t    user_addr_o,
	output logic                   antitear_o,
	output logic                   user_wr_commit_o,
	output logic                   auth_revoke_o,
	output logic [7:0]             fuse_byte_o
);
	import sec_pkg::*;

	if ((ZONE_BYTES & (ZONE_BYTES - 1)) != 0 || ZONE_BYTES < 16 || ZONE_BYTES > 65536)
	begin : g_bad_zone
		$error("ZONE_BYTES must be a power of two from 16 to 65536");
	end

	// ---------------------------------------------------------------
	// Link domain: bit capture on the bus clock
	// ---------------------------------------------------------------
	logic lrst1_reg, lrst2_reg, rise_tgl_reg, bit_cap_reg;

	always_ff @(posedge link_clk_i) begin
		lrst1_reg <= rst_i;
		lrst2_reg <= lrst1_reg;
	end

	// Bit held until the next rising edge, so the core reads it stable
	always_ff @(posedge link_clk_i) begin
		if (lrst2_reg) begin
			rise_tgl_reg <= 1'b0;
			bit_cap_reg  <= 1'b1;
		end else begin
			rise_tgl_reg <= ~rise_tgl_reg;
			bit_cap_reg  <= sda_i;
		end
	end

	// ---------------------------------------------------------------
	// Core domain: pin filters and event detection
	// ---------------------------------------------------------------
	logic [1:0] pin_raw, pin_f, pin_q;
	logic [2:0] tg_reg;
	assign pin_raw = {scl_i, sda_i};

	for (genvar p = 0; p < 2; p++) begin : g_pin
		logic [2:0] s_reg;
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				s_reg    <= 3'h7;
				pin_f[p] <= 1'b1;
				pin_q[p] <= 1'b1;
			end else begin
				s_reg <= {s_reg[1:0], pin_raw[p]};
				if (s_reg[1] == s_reg[2])
					pin_f[p] <= s_reg[2];
				pin_q[p] <= pin_f[p];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			tg_reg <= 3'h0;
		else
			tg_reg <= {tg_reg[1:0], rise_tgl_reg};
	end

	logic scl_f, sda_f, start_ev, stop_ev, rise_ev, fall_ev;
	assign scl_f    = pin_f[1];
	assign sda_f    = pin_f[0];
	assign start_ev = scl_f && pin_q[1] && pin_q[0] && !sda_f;
	assign stop_ev  = scl_f && pin_q[1] && !pin_q[0] && sda_f;
	assign rise_ev  = tg_reg[1] ^ tg_reg[2];
	assign fall_ev  = pin_q[1] && !scl_f;

	// ---------------------------------------------------------------
	// Command state
	// ---------------------------------------------------------------
	sec_state_t st_reg;
	sec_src_t   src_reg;
	logic [3:0]  bcnt_reg;
	logic [7:0]  sh_reg, cmd_reg, a1_reg, a2_reg, tx_reg, wstart_reg;
	logic [8:0]  cnt_reg;
	logic [15:0] addr_reg, ck_reg;
	logic [4:0]  wlen_reg, wmax_reg;
	logic [1:0]  ckn_reg, ld_reg;
	logic        ack_reg, first_reg, bad_reg, wck_reg;
	logic [3:0]  fuse_reg;
	logic [7:0]  wbuf [16];
	logic [7:0]  cfg [256];
	logic [7:0]  rbyte, fbyte, rd_data;
	logic        cfg_we, ck_good;

	assign rbyte   = {sh_reg[6:0], bit_cap_reg};
	assign fbyte   = {4'h0, fuse_reg};
	assign cfg_we  = stop_ev && st_reg == ST_WR && !wck_reg && !bad_reg && wlen_reg != 5'h0;
	assign ck_good = ckn_reg == `SEC_CK_BYTES && ck_reg == checksum_i;

	function automatic logic forbid_rd(input logic [7:0] a);
		return a >= `SEC_CFG_SECURE && !secure_ok_i;
	endfunction : forbid_rd

	function automatic logic forbid_wr(input logic [7:0] a);
		return !secure_ok_i || a < `SEC_CFG_RO_END;
	endfunction : forbid_wr

	always_comb begin
		case (src_reg)
			SRC_USER: rd_data = user_data_i;
			SRC_CFG:  rd_data = forbid_rd(addr_reg[7:0]) ? fbyte : cfg[addr_reg[7:0]];
			SRC_FUSE: rd_data = fbyte;
			SRC_CK:   rd_data = addr_reg[0] ? checksum_i[7:0] : checksum_i[15:8];
			default:  rd_data = 8'hFF;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_reg    <= ST_IDLE;
			src_reg   <= SRC_USER;
			bcnt_reg  <= 4'h0;
			sh_reg    <= 8'h00;
			cmd_reg   <= 8'h00;
			a1_reg    <= 8'h00;
			a2_reg    <= 8'h00;
			cnt_reg   <= 9'h000;
			addr_reg  <= 16'h0000;
			ack_reg   <= 1'b0;
			first_reg <= 1'b0;
			ld_reg    <= 2'h0;
			wlen_reg  <= 5'h00;
			wmax_reg  <= `SEC_PAGE_MAX;
			wstart_reg <= 8'h00;
			bad_reg   <= 1'b0;
			wck_reg   <= 1'b0;
			ckn_reg   <= 2'h0;
			ck_reg    <= 16'h0000;
			fuse_reg  <= FUSE_INIT;
			user_addr_o <= '0;
			antitear_o  <= 1'b0;
		end else begin
			ld_reg <= {ld_reg[0], 1'b0};
			user_addr_o.offset <= addr_reg & 16'(ZONE_BYTES - 1);
			if (start_ev) begin
				st_reg   <= ST_CMD;
				bcnt_reg <= 4'h0;
				ack_reg  <= 1'b0;
			end else if (stop_ev) begin
				st_reg   <= ST_IDLE;
				bcnt_reg <= 4'h0;
				ack_reg  <= 1'b0;
			end else if (rise_ev && bcnt_reg == 4'h8) begin
				bcnt_reg <= 4'h0;
				ack_reg  <= 1'b0;
				if (st_reg == ST_RD) begin
					if (first_reg)
						first_reg <= 1'b0;
					else if (bit_cap_reg || cnt_reg == 9'h001)
						st_reg <= ST_SKIP;
					else
						cnt_reg <= cnt_reg - 9'h001;
				end
			end else if (rise_ev) begin
				bcnt_reg <= bcnt_reg + 4'h1;
				sh_reg   <= rbyte;
				if (bcnt_reg == 4'h7 && st_reg == ST_RD) begin
					addr_reg <= addr_reg + 16'h0001;
					ld_reg   <= 2'h1;
				end else if (bcnt_reg == 4'h7) begin
					ack_reg <= 1'b1;
					case (st_reg)
						ST_CMD: begin
							cmd_reg <= rbyte;
							if ((rbyte[7:4] == `SEC_DEV_ADDR ||
							     rbyte[7:4] == cfg[`SEC_CFG_DEVCFG][3:0]) &&
							    (rbyte[3:0] == `SEC_OP_RD_USER || rbyte[3:0] == `SEC_OP_SYS_WR ||
							     rbyte[3:0] == `SEC_OP_SYS_RD))
								st_reg <= ST_A1;
							else begin
								st_reg  <= ST_SKIP;
								ack_reg <= 1'b0;
							end
						end
						ST_A1: begin
							a1_reg <= rbyte;
							st_reg <= ST_A2;
						end
						ST_A2: begin
							a2_reg <= rbyte;
							st_reg <= ST_CNT;
						end
						ST_CNT: begin
							st_reg    <= ST_SKIP;
							cnt_reg   <= rbyte == 8'h00 ? `SEC_CNT_ZERO : {1'b0, rbyte};
							first_reg <= 1'b1;
							ld_reg    <= 2'h1;
							if (cmd_reg[3:0] == `SEC_OP_RD_USER) begin
								if (zone_read_ok_i) begin
									st_reg   <= ST_RD;
									src_reg  <= SRC_USER;
									addr_reg <= {a1_reg, a2_reg};
								end else
									ack_reg <= 1'b0;
							end else if (cmd_reg[3:0] == `SEC_OP_SYS_RD) begin
								addr_reg <= {8'h00, a2_reg};
								st_reg   <= ST_RD;
								case (a1_reg)
									`SEC_SR_CFG:   src_reg <= SRC_CFG;
									`SEC_SR_FUSE:  src_reg <= SRC_FUSE;
									`SEC_SR_CKSUM: begin
										src_reg  <= SRC_CK;
										addr_reg <= 16'h0000;
									end
									default: begin
										st_reg  <= ST_SKIP;
										ack_reg <= 1'b0;
									end
								endcase
								if (a1_reg == `SEC_SR_CFG && forbid_rd(a2_reg)) begin
									st_reg  <= ST_SKIP;
									ack_reg <= 1'b0;
								end
							end else begin
								case (a1_reg)
									`SEC_SW_CFG, `SEC_SW_CFG_AT: begin
										st_reg     <= ST_WR;
										wck_reg    <= 1'b0;
										wlen_reg   <= 5'h00;
										wstart_reg <= a2_reg;
										addr_reg   <= {8'h00, a2_reg};
										bad_reg    <= forbid_wr(a2_reg);
										wmax_reg   <= a1_reg == `SEC_SW_CFG_AT ?
										              `SEC_AT_MAX : `SEC_PAGE_MAX;
									end
									`SEC_SW_FUSE: begin
										if (!secure_ok_i)
											ack_reg <= 1'b0;
										else begin
											// Only clears are ever issued here
											case (a2_reg)
												`SEC_FID_FACT: fuse_reg[`SEC_FB_FACT] <= 1'b0;
												`SEC_FID_CARD:
													if (!fuse_reg[`SEC_FB_FACT])
														fuse_reg[`SEC_FB_CARD] <= 1'b0;
												`SEC_FID_FINAL:
													if (!fuse_reg[`SEC_FB_CARD])
														fuse_reg[`SEC_FB_FINAL] <= 1'b0;
												`SEC_FID_LOT: fuse_reg[`SEC_FB_LOT] <= 1'b0;
												default: ack_reg <= 1'b0;
											endcase
										end
									end
									`SEC_SW_CKSUM: begin
										st_reg  <= ST_WR;
										wck_reg <= 1'b1;
										ckn_reg <= 2'h0;
									end
									`SEC_SW_ZONE, `SEC_SW_ZONE_AT: begin
										user_addr_o.zone <= a2_reg;
										antitear_o <= a1_reg == `SEC_SW_ZONE_AT;
									end
									default: ack_reg <= 1'b0;
								endcase
							end
						end
						ST_WR: begin
							if (wck_reg) begin
								ck_reg <= {ck_reg[7:0], rbyte};
								if (ckn_reg != 2'h3)
									ckn_reg <= ckn_reg + 2'h1;
							end else begin
								// Overlong or forbidden bytes poison the whole page
								if (wlen_reg == wmax_reg || forbid_wr(addr_reg[7:0]))
									bad_reg <= 1'b1;
								else begin
									wbuf[wlen_reg[3:0]] <= rbyte;
									wlen_reg <= wlen_reg + 5'h01;
								end
								addr_reg <= addr_reg + 16'h0001;
							end
						end
						default: ack_reg <= 1'b0;
					endcase
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration memory and page commit
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < 256; i++)
				cfg[i] <= `SEC_CFG_RESET;
		end else if (cfg_we) begin
			for (int i = 0; i < 16; i++)
				if (5'(i) < wlen_reg)
					cfg[8'(wstart_reg + 8'(i))] <= wbuf[i];
		end
	end

	// ---------------------------------------------------------------
	// Checksum outcome and transmit path
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			user_wr_commit_o <= 1'b0;
			auth_revoke_o    <= 1'b0;
			fuse_byte_o      <= 8'h00;
			tx_reg           <= 8'hFF;
			sda_o            <= 1'b0;
			sda_oe_o         <= 1'b0;
		end else begin
			fuse_byte_o <= fbyte;
			user_wr_commit_o <= stop_ev && st_reg == ST_WR && wck_reg && ck_good &&
			                    user_wr_pending_i;
			auth_revoke_o    <= stop_ev && st_reg == ST_WR && wck_reg && !ck_good;
			if (ld_reg[1])
				tx_reg <= rd_data;
			if (start_ev || stop_ev)
				sda_oe_o <= 1'b0;
			else if (fall_ev) begin
				if (bcnt_reg == 4'h8)
					sda_oe_o <= ack_reg;
				else
					sda_oe_o <= st_reg == ST_RD && !first_reg &&
					            !tx_reg[3'(4'h7 - bcnt_reg)];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_FUSE_ONEWAY: assert property (@(posedge clock_i) disable iff (rst_i)
		(~$past(fuse_reg) & fuse_reg) == 4'h0)
		else $error("fuse bit returned to one");

	AST_FUSE_ORDER: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(fuse_reg[`SEC_FB_FINAL]) |-> !fuse_reg[`SEC_FB_CARD] && !fuse_reg[`SEC_FB_FACT])
		else $error("final fuse programmed out of order");

	AST_FUSE_SECURE: assert property (@(posedge clock_i) disable iff (rst_i)
		$changed(fuse_reg) |-> $past(secure_ok_i))
		else $error("fuse changed without secure code");

	AST_READ_RIGHT: assert property (@(posedge clock_i) disable iff (rst_i)
		rise_ev && bcnt_reg == 4'h7 && st_reg == ST_CNT &&
		cmd_reg[3:0] == `SEC_OP_RD_USER && !zone_read_ok_i
		|=> !ack_reg && st_reg == ST_SKIP)
		else $error("count byte acknowledged without read right");

	AST_CFG_RD_START: assert property (@(posedge clock_i) disable iff (rst_i)
		rise_ev && bcnt_reg == 4'h7 && st_reg == ST_CNT && cmd_reg[3:0] == `SEC_OP_SYS_RD &&
		a1_reg == `SEC_SR_CFG && forbid_rd(a2_reg) |=> !ack_reg ##1 st_reg != ST_RD [*3])
		else $error("forbidden config read started");

	AST_WRITE_SUPPRESS: assert property (@(posedge clock_i) disable iff (rst_i)
		stop_ev && st_reg == ST_WR && !wck_reg && bad_reg |=> $stable(cfg[wstart_reg]))
		else $error("suppressed config write changed memory");

	AST_ANTITEAR: assert property (@(posedge clock_i) disable iff (rst_i)
		rise_ev && bcnt_reg == 4'h7 && st_reg == ST_CNT && cmd_reg[3:0] == `SEC_OP_SYS_WR &&
		(a1_reg == `SEC_SW_ZONE || a1_reg == `SEC_SW_ZONE_AT)
		|=> antitear_o == ($past(a1_reg) == `SEC_SW_ZONE_AT))
		else $error("anti-tearing mode not set by zone select");

	AST_CK_REVOKE: assert property (@(posedge clock_i) disable iff (rst_i)
		stop_ev && st_reg == ST_WR && wck_reg && ck_reg != checksum_i
		|=> auth_revoke_o && !user_wr_commit_o)
		else $error("bad checksum did not revoke");

	AST_FORBID_FILL: assert property (@(posedge clock_i) disable iff (rst_i)
		ld_reg[1] && src_reg == SRC_CFG && forbid_rd(addr_reg[7:0]) |=> tx_reg == fbyte)
		else $error("forbidden byte not replaced by fuse byte");

endmodule : sec_sys_cmd

// ---- bench/sec_host_model.sv ----
`timescale 1ns/100ps
module sec_host_model (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// SCL high and low phases stay well above the pin filter of the device
	localparam int HALF = 10;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wclk(input int n);
		repeat (n) @(posedge clock_i);
	endtask : wclk
	// Bare SCL pulses with SDA released: the link side only resets on SCL edges
	task automatic lclk(input int n, input int h);
		repeat (n) begin
			wclk(h);
			scl_o <= 1'b0;
			wclk(h);
			scl_o <= 1'b1;
		end
	endtask : lclk
	// SDA moves a few cycles after SCL falls, or mid SCL high for start and stop, never beside an SCL edge
	task automatic start_cond();
		wclk(5);
		sda_low_o <= 1'b0;
		wclk(HALF);
		scl_o <= 1'b1;
		wclk(HALF);
		sda_low_o <= 1'b1;
		wclk(HALF);
		scl_o <= 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		wclk(5);
		sda_low_o <= 1'b1;
		wclk(HALF);
		scl_o <= 1'b1;
		wclk(HALF);
		sda_low_o <= 1'b0;
		wclk(HALF);
	endtask : stop_cond
	task automatic bit_io(input logic b, output logic s);
		wclk(5);
		sda_low_o <= ~b;
		wclk(HALF);
		scl_o <= 1'b1;
		wclk(HALF);
		s = sda_i;
		scl_o <= 1'b0;
	endtask : bit_io
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send_byte
	task automatic recv_byte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(~ack, s);
	endtask : recv_byte
	task automatic poll();
		logic a;
		for (int i = 0; i < 20; i++) begin
			start_cond();
			send_byte(8'hB6, a);
			stop_cond();
			if (a) break;
		end
	endtask : poll
endmodule : sec_host_model

// ---- bench/tb_secure_eeprom_system_commands.sv ----
`timescale 1ns/100ps
module tb_secure_eeprom_system_commands;
	import sec_pkg::*;
	localparam int ZB = 16;
	localparam logic [7:0] FID[5] = '{8'h04, 8'h06, 8'h04, 8'h00, 8'h07};
	localparam logic [3:0] FEX[5] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
	localparam logic [7:0] SEL[3] = '{8'h03, 8'h0B, 8'h03};
	logic        clock_i, rst_i, scl, hlow, sda, sda_o, sda_oe_o;
	logic        sec_ok, zr_ok, pend, at_o, commit_o, revoke_o;
	logic [15:0] cks, rv;
	logic [7:0]  udata, fuse_o, rnd, rz;
	logic [3:0]  ak;
	logic [7:0]  rq[$];
	sec_uaddr_t  uaddr;
	int          n_mismatch, total_checks;
	int          cyc = 0, n_commit = 0, n_revoke = 0;
	// Open-drain line with pull-up; user memory content follows its address
	assign sda = ~(hlow | sda_oe_o);
	assign udata = uaddr.offset[7:0] ^ uaddr.zone ^ 8'h5A;
	sec_sys_cmd #(.ZONE_BYTES(ZB), .FUSE_INIT(4'hF)) u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(scl), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .secure_ok_i(sec_ok), .zone_read_ok_i(zr_ok),
		.user_wr_pending_i(pend), .checksum_i(cks), .user_data_i(udata),
		.user_addr_o(uaddr), .antitear_o(at_o), .user_wr_commit_o(commit_o),
		.auth_revoke_o(revoke_o), .fuse_byte_o(fuse_o));
	sec_host_model u_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(hlow));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (commit_o === 1'b1) n_commit <= n_commit + 1;
		if (revoke_o === 1'b1) n_revoke <= n_revoke + 1;
		if (cyc == 99000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ---------------------------------------------------------------
	// Checks and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tdone(input string nm);
		$display("test %s done, mismatches %0d", nm, n_mismatch);
	endtask : tdone
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic hdr(input logic [7:0] c, a1, a2, n);
		logic [31:0] w;
		logic        a;
		w = {c, a1, a2, n};
		u_host.start_cond();
		for (int i = 3; i >= 0; i--) begin
			u_host.send_byte(w[i*8+:8], a);
			ak[i] = a;
		end
	endtask : hdr
	task automatic rd(input logic [7:0] c, a1, a2, n, input int k);
		logic [7:0] b;
		hdr(c, a1, a2, n);
		rq.delete();
		if (ak[0] === 1'b1) begin
			for (int i = 0; i < k; i++) begin
				u_host.recv_byte(i < k - 1, b);
				rq.push_back(b);
			end
		end
		u_host.stop_cond();
	endtask : rd
	// Write config bytes, then read them back: either the data or untouched 0xFF
	task automatic cw(input logic [7:0] a1, ad, input int n, input logic ok);
		logic [7:0] d[$];
		logic       a;
		for (int i = 0; i < n; i++) d.push_back(8'($urandom));
		hdr(8'hB4, a1, ad, 8'(n));
		chk("cfg wr ack", 16'h000F, {12'h0, ak});
		foreach (d[i]) u_host.send_byte(d[i], a);
		u_host.stop_cond();
		u_host.poll();
		rd(8'hB6, 8'h00, ad, 8'(n), n);
		foreach (d[i]) chk("cfg data", {8'h0, ok ? d[i] : 8'hFF}, {8'h0, rq[i]});
	endtask : cw
	task automatic fz(input logic [7:0] id, input logic [3:0] e, ea);
		hdr(8'hB4, 8'h01, id, 8'h00);
		u_host.stop_cond();
		u_host.poll();
		chk("fuse ack", {12'h0, ea}, {12'h0, ak});
		chk("fuse port", {12'h0, e}, {8'h0, fuse_o});
		rd(8'hB6, 8'h01, 8'h00, 8'h01, 1);
		chk("fuse rd", {12'h0, e}, {8'h0, rq[0]});
	endtask : fz
	task automatic ck(input logic [15:0] v, input logic good);
		logic a;
		int   c0, r0;
		c0 = n_commit;
		r0 = n_revoke;
		hdr(8'hB4, 8'h02, 8'h00, 8'h02);
		u_host.send_byte(v[15:8], a);
		u_host.send_byte(v[7:0], a);
		u_host.stop_cond();
		u_host.poll();
		chk("commit", {15'h0, good}, 16'(n_commit - c0));
		chk("revoke", {15'h0, ~good}, 16'(n_revoke - r0));
	endtask : ck
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		total_checks = 0;
		rst_i = 1'b1;
		{sec_ok, zr_ok, pend} = 3'h0;
		cks = 16'h0000;
		rnd = 8'($urandom(32'h0779));
		// Link logic resets only on SCL edges: pulse SCL in reset and after it
		u_host.lclk(2, 1);
		rst_i <= 1'b0;
		u_host.lclk(3, 10);
		repeat (10) @(posedge clock_i);
		u_host.poll();
		rd(8'hB6, 8'h01, 8'h00, 8'h01, 1);
		chk("fuse rd", 16'h000F, {8'h0, rq[0]});
		tdone("fuse byte");
		rv = 16'($urandom);
		cks <= rv;
		rd(8'hB6, 8'h02, 8'h00, 8'h02, 2);
		chk("cks hi", {8'h0, rv[15:8]}, {8'h0, rq[0]});
		chk("cks lo", {8'h0, rv[7:0]}, {8'h0, rq[1]});
		tdone("checksum read");
		do rnd = 8'($urandom); while (rnd[7:4] == 4'hB || rnd[7:4] == 4'hF);
		rd({rnd[7:4], 4'h6}, 8'h01, 8'h00, 8'h01, 1);
		chk("bad addr ack", 16'h0000, {12'h0, ak});
		rd(8'hF6, 8'h01, 8'h00, 8'h01, 1);
		chk("cfg addr ack", 16'h000F, {12'h0, ak});
		tdone("addressing");
		rd(8'hB6, 8'h00, 8'hB0, 8'h04, 4);
		chk("locked ack", 16'h000E, {12'h0, ak});
		chk("locked len", 16'h0000, 16'(rq.size()));
		rd(8'hB6, 8'h00, 8'hAE, 8'h04, 4);
		for (int i = 0; i < 4; i++) chk("cross", i < 2 ? 16'hFF : 16'h0F, {8'h0, rq[i]});
		tdone("cfg read rights");
		fz(8'h06, 4'hF, 4'hE);
		cw(8'h00, 8'h20, 2, 1'b0);
		sec_ok <= 1'b1;
		cw(8'h00, 8'h20, 2, 1'b1);
		cw(8'h00, 8'h08, 4, 1'b0);
		cw(8'h00, 8'h40, 16, 1'b1);
		cw(8'h08, 8'h50, 9, 1'b0);
		cw(8'h08, 8'h50, 8, 1'b1);
		tdone("cfg write");
		for (int i = 0; i < 5; i++) fz(FID[i], FEX[i], 4'hF);
		tdone("fuses");
		rz = 8'($urandom);
		for (int i = 0; i < 3; i++) begin
			hdr(8'hB4, SEL[i], rz, 8'h00);
			u_host.stop_cond();
			chk("antitear", {15'h0, SEL[i] == 8'h0B}, {15'h0, at_o});
		end
		chk("sda level", 16'h0000, {15'h0, sda_o});
		rd(8'hB2, 8'h00, 8'h0E, 8'h04, 4);
		chk("no right ack", 16'h000E, {12'h0, ak});
		zr_ok <= 1'b1;
		rd(8'hB2, 8'h00, 8'h0E, 8'h00, 18);
		for (int i = 0; i < 18; i++) chk("user", {8'h0, 8'((14 + i) % ZB) ^ rz ^ 8'h5A},
			{8'h0, rq[i]});
		tdone("user read");
		pend <= 1'b1;
		rv = 16'($urandom);
		cks <= rv;
		ck(rv, 1'b1);
		ck(rv ^ 16'h0001, 1'b0);
		tdone("send checksum");
		end_sim();
	end
endmodule : tb_secure_eeprom_system_commands
